// ===== verilog/system_options_control.sv
module system_options_control
(
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 por,
	input  wire logic                 clk_en,
	input  wire sysopt_pkg::bus_req_t req,
	output sysopt_pkg::bus_resp_t     resp,
	output sysopt_pkg::sys_cfg_t      cfg,
	output logic                      debug_reset_req,
	input  wire logic                 stop_exec,
	output logic                      stop_grant,
	output logic                      illegal_stop_reset,
	input  wire logic                 watchdog_last_quarter,
	output logic                      watchdog_restart,
	output logic                      watchdog_fault,
	input  wire logic                 comparator_out,
	input  wire logic [3:0]           timer_ch_out,
	input  wire logic [3:0]           timer_ch_oe,
	output logic      [3:0]           timer_ch_in,
	input  wire logic [3:0]           main_pin_in,
	output logic      [3:0]           main_pin_out,
	output logic      [3:0]           main_pin_oe,
	input  wire logic [3:0]           alt_pin_in,
	output logic      [3:0]           alt_pin_out,
	output logic      [3:0]           alt_pin_oe
);
	import sysopt_pkg::*;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	logic [7:0] opt1;
	logic       opt1_locked;
	logic       reset_pin_en;
	logic [7:0] opt2;
	logic       opt2_locked;
	logic       service_armed;
	logic [3:0] main_meta;
	logic [3:0] main_sync;
	logic [3:0] alt_meta;
	logic [3:0] alt_sync;

	logic       wr;
	logic       rd;
	logic       wr_force;
	logic       wr_opt1;
	logic       wr_opt2;
	logic       wr_status;
	logic [7:0] opt1_view;
	logic [7:0] next_rdata;

	assign wr        = clk_en && req.valid && req.write;
	assign rd        = clk_en && req.valid && !req.write;
	assign wr_force  = wr && req.addr == OFS_DEBUG_FORCE_RESET;
	assign wr_opt1   = wr && req.addr == OFS_OPTIONS_ONE;
	assign wr_opt2   = wr && req.addr == OFS_OPTIONS_TWO;
	assign wr_status = wr && req.addr == OFS_RESET_STATUS;

	// the reset-pin bit lives apart so power-on alone clears it
	assign opt1_view = {opt1[7:1], reset_pin_en} & OPT1_MASK;

	// first write after reset wins, later ones dropped
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			opt1        <= OPT1_RESET;
			opt1_locked <= 1'b0;
		end
		else if (wr_opt1 && !opt1_locked)
		begin
			opt1        <= req.wdata & OPT1_MASK;
			opt1_locked <= 1'b1;
		end
	end

	// internal resets leave the reset-pin function alone
	always_ff @(posedge mclk)
	begin
		if (por)
			reset_pin_en <= 1'b0;
		else if (wr_opt1 && !opt1_locked && req.wdata[BIT_RESET_PIN])
			reset_pin_en <= 1'b1;
	end

	// locks cleared by any reset, first write honoured again
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			opt2        <= OPT2_RESET;
			opt2_locked <= 1'b0;
		end
		else if (wr_opt2)
		begin
			// watchdog clock and window bits are write-once
			if (!opt2_locked)
			begin
				opt2        <= req.wdata & OPT2_MASK;
				opt2_locked <= 1'b1;
			end
			else
				opt2 <= (opt2 & OPT2_ONCE_MASK) | (req.wdata & OPT2_MASK & ~OPT2_ONCE_MASK);
		end
	end

	// only a background-link write can force a reset
	always_ff @(posedge mclk)
	begin
		if (reset)
			debug_reset_req <= 1'b0;
		else if (clk_en)
			// debug write of one requests full reset
			debug_reset_req <= wr_force && req.debug && req.wdata[BIT_FORCE_RESET];
	end
	// this request is kept off every status-flag source line

	// stop refused becomes an illegal-opcode reset
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			stop_grant         <= 1'b0;
			illegal_stop_reset <= 1'b0;
		end
		else if (clk_en)
		begin
			stop_grant         <= stop_exec && opt1[BIT_STOP_ALLOW];
			illegal_stop_reset <= stop_exec && !opt1[BIT_STOP_ALLOW];
		end
	end

	// service pair snooped on the status address
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			service_armed    <= 1'b0;
			watchdog_restart <= 1'b0;
			watchdog_fault   <= 1'b0;
		end
		else if (clk_en)
		begin
			watchdog_restart <= 1'b0;
			watchdog_fault   <= 1'b0;
			if (wr_status && cfg.watchdog_enabled)
			begin
				// with the window active, any write before the last quarter resets
				if (cfg.watchdog_window_active && !watchdog_last_quarter)
				begin
					watchdog_fault <= 1'b1;
					service_armed  <= 1'b0;
				end
				else if (req.wdata == SERVICE_FIRST)
					service_armed <= 1'b1;
				else if (req.wdata == SERVICE_SECOND && service_armed)
				begin
					watchdog_restart <= 1'b1;
					service_armed    <= 1'b0;
				end
				else
				begin
					watchdog_fault <= 1'b1;
					service_armed  <= 1'b0;
				end
			end
		end
	end

	always_comb
	begin
		next_rdata = 8'h00;
		unique case (req.addr)
			OFS_DEBUG_FORCE_RESET: next_rdata = 8'h00;
			OFS_OPTIONS_ONE:       next_rdata = opt1_view;
			OFS_OPTIONS_TWO:       next_rdata = opt2 & OPT2_MASK;
			// top bit zero, reserved bits read zero
			OFS_IDENT_HIGH:        next_rdata = {4'h0, PART_NUMBER[11:8]};
			OFS_IDENT_LOW:         next_rdata = PART_NUMBER[7:0];
			default:               next_rdata = 8'h00;
		endcase
	end

	// read answer one cycle after the request
	always_ff @(posedge mclk)
	begin
		if (reset)
			resp <= '0;
		else if (clk_en)
		begin
			resp.valid <= rd;
			if (rd)
				resp.data <= next_rdata;
		end
	end

	always_comb
	begin
		// timeout field forwarded with the clock select
		cfg.watchdog_timeout_sel   = opt1[BIT_TIMEOUT_HI:BIT_TIMEOUT_LO];
		cfg.watchdog_enabled       = opt1[BIT_TIMEOUT_HI:BIT_TIMEOUT_LO] != 2'b00;
		cfg.watchdog_bus_clock     = opt2[BIT_WDOG_CLOCK];
		// window ignored on the 1 kHz clock
		cfg.watchdog_window_active = opt2[BIT_WDOG_WINDOW] && opt2[BIT_WDOG_CLOCK];
		cfg.stop_allow             = opt1[BIT_STOP_ALLOW];
		// two-wire pins move to port B when set
		cfg.twowire_on_port_b      = opt1[BIT_TWOWIRE_SEL];
		cfg.debug_pin_enable       = opt1[BIT_DEBUG_PIN];
		cfg.reset_pin_enable       = reset_pin_en;
		cfg.reset_pin_pullup       = reset_pin_en;
		cfg.comparator_to_capture  = opt2[BIT_CMP_TO_CAPTURE];
	end

	// pin levels are asynchronous, two flops before use
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			main_meta <= 4'h0;
			main_sync <= 4'h0;
			alt_meta  <= 4'h0;
			alt_sync  <= 4'h0;
		end
		else if (clk_en)
		begin
			main_meta <= main_pin_in;
			main_sync <= main_meta;
			alt_meta  <= alt_pin_in;
			alt_sync  <= alt_meta;
		end
	end

	// channel i follows option-two bit i: t1c0, t1c1, t2c0, t2c1
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++)
		begin : g_chan
			assign main_pin_out[ch] = opt2[ch] ? 1'b0 : timer_ch_out[ch];
			assign main_pin_oe[ch]  = !opt2[ch] && timer_ch_oe[ch];
			assign alt_pin_out[ch]  = opt2[ch] ? timer_ch_out[ch] : 1'b0;
			assign alt_pin_oe[ch]   = opt2[ch] && timer_ch_oe[ch];
			if (ch == 0)
			begin : g_cmp
				// comparator replaces the pin on capture zero
				assign timer_ch_in[ch] = opt2[BIT_CMP_TO_CAPTURE] ? comparator_out
					: (opt2[ch] ? alt_sync[ch] : main_sync[ch]);
			end
			else
			begin : g_pin
				assign timer_ch_in[ch] = opt2[ch] ? alt_sync[ch] : main_sync[ch];
			end
		end
	endgenerate

	user_write_ignored_a: assert property (
		wr_force && !req.debug |=> !debug_reset_req)
		else $error("user write forced a reset");

	force_reads_zero_a: assert property (
		rd && req.addr == OFS_DEBUG_FORCE_RESET |=> resp.valid && resp.data == 8'h00)
		else $error("force-reset register read nonzero");

	debug_force_a: assert property (
		wr_force && req.debug && req.wdata[BIT_FORCE_RESET] |=> debug_reset_req ##1 !debug_reset_req)
		else $error("debug force reset not a single pulse");

	options_lock_a: assert property (
		opt1_locked |=> $stable(opt1) && opt1_locked)
		else $error("options one changed after lock");

	stop_refused_a: assert property (
		clk_en && stop_exec && !cfg.stop_allow |=> illegal_stop_reset && !stop_grant)
		else $error("refused stop not turned into reset");

	// reset is the trigger here, so the default disable must not mask it
	debug_pin_back_a: assert property (
		@(posedge mclk) disable iff (1'b0) reset |=> cfg.debug_pin_enable && !opt1_locked)
		else $error("debug pin not restored by reset");

	// must hold straight through internal resets, hence no disable
	reset_pin_kept_a: assert property (
		@(posedge mclk) disable iff (1'b0) reset_pin_en && !por |=> reset_pin_en)
		else $error("reset pin function lost");

	twowire_follows_a: assert property (
		cfg.twowire_on_port_b == opt1[BIT_TWOWIRE_SEL])
		else $error("two-wire pin select disagrees");

	capture_source_a: assert property (
		opt2[BIT_CMP_TO_CAPTURE] |-> timer_ch_in[0] == comparator_out)
		else $error("comparator not routed to capture zero");

	pullup_follows_a: assert property (
		cfg.reset_pin_pullup == cfg.reset_pin_enable)
		else $error("pull-up disagrees with reset pin");

	early_service_a: assert property (
		wr_status && cfg.watchdog_enabled && cfg.watchdog_window_active
		&& !watchdog_last_quarter |=> watchdog_fault && !watchdog_restart)
		else $error("early service not faulted");

	window_bus_only_a: assert property (
		cfg.watchdog_window_active |-> cfg.watchdog_bus_clock)
		else $error("window active on slow clock");

	ident_top_zero_a: assert property (
		rd && req.addr == OFS_IDENT_HIGH |=> resp.data[7:4] == 4'h0)
		else $error("ident high upper bits nonzero");

	service_pair_a: assert property (
		wr_status && cfg.watchdog_enabled && !cfg.watchdog_window_active
		&& req.wdata == SERVICE_FIRST
		##1 wr_status && req.wdata == SERVICE_SECOND |=> watchdog_restart)
		else $error("service pair did not restart watchdog");

	bad_service_a: assert property (
		wr_status && cfg.watchdog_enabled && req.wdata != SERVICE_FIRST
		&& req.wdata != SERVICE_SECOND |=> watchdog_fault)
		else $error("bad service value not faulted");

endmodule

// ===== verilog/sysopt_pkg.sv
package sysopt_pkg;

	typedef struct packed
	{
		logic       valid;
		logic       write;
		logic       debug;
		logic [2:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	typedef struct packed
	{
		logic       valid;
		logic [7:0] data;
	} bus_resp_t;

	typedef struct packed
	{
		logic [1:0] watchdog_timeout_sel;
		logic       watchdog_enabled;
		logic       watchdog_bus_clock;
		logic       watchdog_window_active;
		logic       stop_allow;
		logic       twowire_on_port_b;
		logic       debug_pin_enable;
		logic       reset_pin_enable;
		logic       reset_pin_pullup;
		logic       comparator_to_capture;
	} sys_cfg_t;

	// register addresses on the internal register port
	localparam logic [2:0] OFS_DEBUG_FORCE_RESET = 3'h0;
	localparam logic [2:0] OFS_OPTIONS_ONE       = 3'h1;
	localparam logic [2:0] OFS_OPTIONS_TWO       = 3'h2;
	localparam logic [2:0] OFS_IDENT_HIGH        = 3'h3;
	localparam logic [2:0] OFS_IDENT_LOW         = 3'h4;
	localparam logic [2:0] OFS_RESET_STATUS      = 3'h5;

	// field positions
	localparam int BIT_FORCE_RESET      = 0;
	localparam int BIT_TIMEOUT_HI       = 7;
	localparam int BIT_TIMEOUT_LO       = 6;
	localparam int BIT_STOP_ALLOW       = 5;
	localparam int BIT_TWOWIRE_SEL      = 2;
	localparam int BIT_DEBUG_PIN        = 1;
	localparam int BIT_RESET_PIN        = 0;
	localparam int BIT_WDOG_CLOCK       = 7;
	localparam int BIT_WDOG_WINDOW      = 6;
	localparam int BIT_CMP_TO_CAPTURE   = 4;
	localparam int BIT_IDENT_ZERO       = 7;

	// implemented bits, write-once bits and reset values
	localparam logic [7:0] OPT1_MASK      = 8'hE7;
	localparam logic [7:0] OPT1_RESET     = 8'hC2;
	localparam logic [7:0] OPT2_MASK      = 8'hDF;
	localparam logic [7:0] OPT2_ONCE_MASK = 8'hC0;
	localparam logic [7:0] OPT2_RESET     = 8'h00;

	// arbitrary part number, not tied to any real derivative
	localparam logic [11:0] PART_NUMBER = 12'h0A5;

	localparam logic [7:0] SERVICE_FIRST  = 8'h55;
	localparam logic [7:0] SERVICE_SECOND = 8'hAA;

endpackage

// ===== tb/debug_host_model.sv
module debug_host_model
(
	input  wire logic           mclk,
	output sysopt_pkg::bus_req_t host_req
);
	timeunit 1ns;
	timeprecision 100ps;
	import sysopt_pkg::*;

	initial host_req = '0;

	task automatic send(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		host_req <= '{1'b1, 1'b1, 1'b1, a, d};
		@(posedge mclk);
		// a released link shows no stale data
		host_req.valid <= 1'b0;
		host_req.wdata <= ~d;
	endtask
endmodule

// ===== tb/tb_top.sv
`define CHK(nm, ex, gt) \
	begin num_checks++; if ((gt) !== (ex)) \
	begin err_count++; $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sysopt_pkg::*;

	logic       mclk = 1'b0;
	logic       reset = 1'b1;
	logic       por = 1'b1;
	logic       stop_exec = 1'b0;
	logic       clk_en = 1'b1;
	logic [3:0] main_out;
	logic [3:0] alt_out;
	logic       last_q = 1'b0;
	logic       cmp_out = 1'b1;
	logic [3:0] main_in = 4'hC;
	logic [3:0] alt_in = 4'h2;
	logic [3:0] ch_in;
	logic [3:0] main_oe;
	logic [3:0] alt_oe;
	logic [4:0] pulses;
	bus_req_t   user_req = '0;
	bus_req_t   host_req;
	bus_req_t   req;
	bus_resp_t  resp;
	sys_cfg_t   cfg;
	int         err_count = 0;
	int         num_checks = 0;

	always #5 mclk = ~mclk;
	assign req = host_req.valid ? host_req : user_req;

	debug_host_model i_debug_host_model (.mclk(mclk), .host_req(host_req));

	system_options_control i_system_options_control
	(
		.mclk(mclk), .reset(reset), .por(por), .clk_en(clk_en), .req(req), .resp(resp),
		.cfg(cfg), .debug_reset_req(pulses[4]), .stop_exec(stop_exec),
		.stop_grant(pulses[3]), .illegal_stop_reset(pulses[2]),
		.watchdog_last_quarter(last_q), .watchdog_restart(pulses[1]),
		.watchdog_fault(pulses[0]), .comparator_out(cmp_out), .timer_ch_out(4'h6),
		.timer_ch_oe(4'hF), .timer_ch_in(ch_in), .main_pin_in(main_in),
		.main_pin_out(main_out), .main_pin_oe(main_oe), .alt_pin_in(alt_in),
		.alt_pin_out(alt_out), .alt_pin_oe(alt_oe)
	);

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic rst(input logic p);
		@(posedge mclk);
		reset <= 1'b1;
		por <= p;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		por <= 1'b0;
	endtask

	// every write also checks the five pulse outputs one cycle later
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic [4:0] ep);
		@(posedge mclk);
		user_req <= '{1'b1, 1'b1, 1'b0, a, d};
		@(posedge mclk);
		user_req.valid <= 1'b0;
		#1;
		`CHK("pulses", ep, pulses)
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] ex, input logic [7:0] m);
		logic [8:0] got;
		@(posedge mclk);
		user_req <= '{1'b1, 1'b0, 1'b0, a, 8'h00};
		@(posedge mclk);
		user_req.valid <= 1'b0;
		#1;
		got = {resp.valid, resp.data & m};
		`CHK("read", {1'b1, ex & m}, got)
	endtask

	task automatic stp(input logic [4:0] ep);
		@(posedge mclk);
		stop_exec <= 1'b1;
		@(posedge mclk);
		stop_exec <= 1'b0;
		#1;
		`CHK("stop", ep, pulses)
	endtask

	task automatic pins(input logic [7:0] o2, input logic [3:0] ein);
		wr(OFS_OPTIONS_TWO, o2, 5'h00);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("main_oe", ~o2[3:0], main_oe)
		`CHK("alt_oe", o2[3:0], alt_oe)
		`CHK("main_out", ~o2[3:0] & 4'h6, main_out)
		`CHK("alt_out", o2[3:0] & 4'h6, alt_out)
		`CHK("ch_in", ein, ch_in)
	endtask

	initial
	begin
		#20000;
		err_count++;
		print_verdict();
	end

	initial
	begin
		rst(1'b1);
		rd(OFS_OPTIONS_ONE, OPT1_RESET, 8'hFF);
		clk_en <= 1'b0;
		wr(OFS_OPTIONS_ONE, 8'h3D, 5'h00);
		clk_en <= 1'b1;
		rd(OFS_OPTIONS_ONE, OPT1_RESET, 8'hFF);
		rd(OFS_OPTIONS_TWO, OPT2_RESET, 8'hFF);
		rd(OFS_IDENT_HIGH, {4'h0, PART_NUMBER[11:8]}, 8'h8F);
		wr(OFS_IDENT_LOW, ~PART_NUMBER[7:0], 5'h00);
		rd(OFS_IDENT_LOW, PART_NUMBER[7:0], 8'hFF);
		wr(OFS_DEBUG_FORCE_RESET, 8'h01, 5'h00);
		i_debug_host_model.send(OFS_DEBUG_FORCE_RESET, 8'h01);
		#1;
		`CHK("host_reset", 5'h10, pulses)
		rd(OFS_DEBUG_FORCE_RESET, 8'h00, 8'hFF);
		wr(OFS_OPTIONS_ONE, 8'h3D, 5'h00);
		rd(OFS_OPTIONS_ONE, 8'h25, 8'hFF);
		wr(OFS_OPTIONS_ONE, 8'hC2, 5'h00);
		rd(OFS_OPTIONS_ONE, 8'h25, 8'hFF);
		`CHK("twowire", 1'b1, cfg.twowire_on_port_b)
		`CHK("dbg_pin", 1'b0, cfg.debug_pin_enable)
		`CHK("pullup", 1'b1, cfg.reset_pin_pullup)
		`CHK("wd_en", 1'b0, cfg.watchdog_enabled)
		stp(5'h08);
		wr(OFS_RESET_STATUS, 8'h12, 5'h00);
		rst(1'b0);
		rd(OFS_OPTIONS_ONE, 8'hC3, 8'hFF);
		stp(5'h04);
		wr(OFS_OPTIONS_ONE, 8'h20, 5'h00);
		rd(OFS_OPTIONS_ONE, 8'h21, 8'hFF);
		wr(OFS_OPTIONS_TWO, 8'hFF, 5'h00);
		rd(OFS_OPTIONS_TWO, 8'hDF, 8'hFF);
		wr(OFS_OPTIONS_TWO, 8'h00, 5'h00);
		rd(OFS_OPTIONS_TWO, 8'hC0, 8'hFF);
		`CHK("window", 1'b1, cfg.watchdog_window_active)
		`CHK("bus_clk", 1'b1, cfg.watchdog_bus_clock)
		rst(1'b0);
		wr(OFS_OPTIONS_TWO, 8'h80, 5'h00);
		`CHK("no_window", 1'b0, cfg.watchdog_window_active)
		rst(1'b0);
		wr(OFS_OPTIONS_TWO, 8'hC0, 5'h00);
		`CHK("timeout", 2'b11, cfg.watchdog_timeout_sel)
		wr(OFS_RESET_STATUS, SERVICE_FIRST, 5'h01);
		@(posedge mclk);
		last_q <= 1'b1;
		wr(OFS_RESET_STATUS, SERVICE_FIRST, 5'h00);
		wr(OFS_RESET_STATUS, SERVICE_SECOND, 5'h02);
		wr(OFS_RESET_STATUS, 8'h12, 5'h01);
		pins(8'h15, 4'h9);
		pins(8'h05, 4'h8);
		pins(8'h0A, 4'h6);
		rst(1'b1);
		rd(OFS_OPTIONS_ONE, OPT1_RESET, 8'hFF);
		print_verdict();
	end
endmodule
